/* rtl/thr_pkg.sv */
`default_nettype none
package thr_pkg;

	// clock and timing figures
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SPIKE_NS = 50;
	// a spike of the full width must never reach the stable count, hence one extra sample
	localparam int SPIKE_CYCLES = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int CONV_MS_12 = 750;
	localparam int CONV_CYCLES_12 = int'((longint'(CONV_MS_12) * 64'd1000000000) / CLK_PERIOD_PS);
	localparam int NVW_MAX_MS = 10;
	localparam int NVW_TYP_MS = 4;
	localparam int NVW_CYCLES = int'((longint'(NVW_MAX_MS) * 64'd1000000000) / CLK_PERIOD_PS);

	// register reset and factory values
	localparam logic [15:0] TEMP_POR = 16'hC400;
	localparam logic [15:0] UPPER_FACTORY = 16'h0F00;
	localparam logic [15:0] LOWER_FACTORY = 16'h0A00;
	localparam logic [5:0] CFG_VOL_POR = 6'h23;
	localparam logic [1:0] CFG_NV_FACTORY = 2'h0;
	localparam logic [15:0] RES_MASK_12 = 16'hFFF0;

	// configuration byte layout
	localparam int CFG_DONE = 7;
	localparam int CFG_HIGH_FLAG = 6;
	localparam int CFG_LOW_FLAG = 5;
	localparam int CFG_NV_BUSY = 4;
	localparam int CFG_RES_HI = 3;
	localparam int CFG_RES_LO = 2;
	localparam int CFG_POL = 1;
	localparam int CFG_ONESHOT = 0;

	// serial bus address and commands
	localparam logic [3:0] BUS_ADDR_FIXED = 4'h9;
	localparam logic [7:0] CMD_START = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] CMD_TEMP = 8'h10;
	localparam logic [7:0] CMD_UPPER = 8'h11;
	localparam logic [7:0] CMD_LOWER = 8'h12;
	localparam logic [7:0] CMD_CFG = 8'h13;
	localparam logic [7:0] RD_FILL = 8'hFF;

	// nonvolatile word addresses
	localparam logic [1:0] MEM_UPPER = 2'h0;
	localparam logic [1:0] MEM_LOWER = 2'h1;
	localparam logic [1:0] MEM_CFG = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_CMD   = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h6
	} thr_bus_e;

	typedef enum logic [1:0] {
		PTR_TEMP  = 2'h0,
		PTR_UPPER = 2'h1,
		PTR_LOWER = 2'h2,
		PTR_CFG   = 2'h3
	} thr_ptr_e;

endpackage : thr_pkg
`default_nettype wire

/* rtl/thr_nv_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface thr_nv_if;
	logic        we;
	logic [1:0]  waddr;
	logic [15:0] wdata;
	logic [15:0] upper;
	logic [15:0] lower;
	logic [1:0]  cfgNv;

	modport core (output we, output waddr, output wdata, input upper, input lower, input cfgNv);
	modport mem (input we, input waddr, input wdata, output upper, output lower, output cfgNv);
endinterface : thr_nv_if
`default_nettype wire

/* rtl/thr_spike_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_spike_filter #(
	parameter int STABLE = thr_pkg::SPIKE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      level
);
	import thr_pkg::*;

	localparam int CW = $clog2(STABLE + 1);

	generate
		if (STABLE < 1)
		begin : g_chk
			$error("thr_spike_filter: STABLE must be at least 1");
		end
	endgenerate

	typedef struct packed {
		logic          s0;
		logic          s1;
		logic          lvl;
		logic [CW-1:0] cnt;
	} thr_filt_s;

	thr_filt_s q, n;

	// a new level is taken only after it has held for STABLE samples
	always_comb
	begin
		n = q;
		n.s0 = pinIn;
		n.s1 = q.s0;
		if (q.s1 == q.lvl)
			n.cnt = '0;
		else if (q.cnt == CW'(STABLE - 1))
		begin
			n.lvl = q.s1;
			n.cnt = '0;
		end
		else
			n.cnt = q.cnt + CW'(1);
	end

	// idle bus lines rest high
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q     <= '0;
			q.s0  <= 1'b1;
			q.s1  <= 1'b1;
			q.lvl <= 1'b1;
		end
		else
			q <= n;
	end

	assign level = q.lvl;
endmodule : thr_spike_filter
`default_nettype wire

/* rtl/thr_nv_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_nv_mem (
	input  wire logic clk,
	input  wire logic rst,
	thr_nv_if.mem     nv
);
	import thr_pkg::*;

	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
		logic [1:0]  cfg;
	} thr_mem_s;

	thr_mem_s q, n;

	// one word written per commit pulse
	always_comb
	begin
		n = q;
		if (nv.we)
		begin
			case (nv.waddr)
				MEM_UPPER: n.upper = nv.wdata;
				MEM_LOWER: n.lower = nv.wdata;
				MEM_CFG:   n.cfg = nv.wdata[1:0];
				default:   n = q;
			endcase
		end
	end

	// reset models the shipped contents; real storage would keep its words
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q.upper <= UPPER_FACTORY;
			q.lower <= LOWER_FACTORY;
			q.cfg   <= CFG_NV_FACTORY;
		end
		else
			q <= n;
	end

	assign nv.upper = q.upper;
	assign nv.lower = q.lower;
	assign nv.cfgNv = q.cfg;
endmodule : thr_nv_mem
`default_nettype wire

/* rtl/thr_thermo_core.sv */
// Overview of operation
// [R1] last measured temperature held as two's complement word; host reads, cannot write
// [R2] temperature word reads C400 after power-up until a conversion completes
// [R3] upper trip point: 16-bit nonvolatile read/write, shipped as 0F00
// [R4] lower trip point: 16-bit nonvolatile read/write, shipped as 0A00
// [R5] configuration: six upper bits volatile, polarity and single-conversion bits nonvolatile
// [R6] configuration upper bits power up 100011; low two come from storage
// [R7] nonvolatile write completes within 10 ms; host waits before relying on it
// [R8] data line only pulled low for acknowledge or read data, else released
// [R9] host makes the serial clock; the device only listens to it
// [R10] thermostat output driven both high and low
// [R11] bus inputs ignore glitches up to 50 ns wide
// [R12] resolution 9 to 12 bits by two configuration bits, 12 after power-up
// [R13] lowest four temperature bits and bits below resolution read zero
// [R14] thermostat active at or above upper trip, until below lower trip
// [R15] conversion lasts 93.75, 187.5, 375 or 750 ms by resolution
// [R16] writes to read-only temperature or configuration bits change nothing
`timescale 1ns/1ps
`default_nettype none
module thr_thermo_core #(
	parameter int CONV_CYCLES = thr_pkg::CONV_CYCLES_12,
	parameter int NVW_CYCLES  = thr_pkg::NVW_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	output logic             thermostatOutput,
	input  wire logic        addressSelect0,
	input  wire logic        addressSelect1,
	input  wire logic        addressSelect2,
	input  wire logic [11:0] sensorCode
);
	import thr_pkg::*;

	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int NW = $clog2(NVW_CYCLES + 1);

	generate
		if (CONV_CYCLES < 8 || NVW_CYCLES < 2)
		begin : g_chk
			$error("thr_thermo_core: CONV_CYCLES must be >= 8 and NVW_CYCLES >= 2");
		end
	endgenerate

	typedef struct packed {
		logic [2:0]    adrS0;
		logic [2:0]    adrS1;
		logic          sclD;
		logic          sdaD;
		thr_bus_e      st;
		logic          ackPh;
		logic [3:0]    bitCnt;
		logic [7:0]    rx;
		logic [7:0]    tx;
		logic          hostAck;
		logic [1:0]    byteIdx;
		thr_ptr_e      ptr;
		logic [7:0]    wrMsb;
		logic          sdaOe;
		logic          sdaOut;
		logic          thermostat_output;
		logic [15:0]   temp;
		logic          done;
		logic          hiFlag;
		logic          loFlag;
		logic [1:0]    res;
		logic          convRun;
		logic [CW-1:0] convCnt;
		logic          thermActive;
		logic [NW-1:0] nvCnt;
		logic [1:0]    nvAddr;
		logic [15:0]   nvData;
	} thr_core_s;

	thr_core_s   q, n;
	thr_nv_if    nv ();
	logic        sclF;
	logic        sdaF;
	logic        sclRise;
	logic        sclFall;
	logic        busStart;
	logic        busStop;
	logic        nvBusy;
	logic [15:0] mask;
	logic [7:0]  cfgByte;

	// bits below the selected resolution, and the four lowest always, read as zero
	function automatic logic [15:0] resMask(input logic [1:0] r);
		resMask = RES_MASK_12 << (2'd3 - r); // R13
	endfunction : resMask

	// conversion length halves per bit of resolution given up
	function automatic logic [CW-1:0] convLen(input logic [1:0] r);
		convLen = CW'(CONV_CYCLES >> (2'd3 - r)); // R15
	endfunction : convLen

	// read byte for pointer and byte index; bytes past the register read as fill
	function automatic logic [7:0] rdByte(
		input thr_ptr_e    p,
		input logic [1:0]  i,
		input logic [15:0] t,
		input logic [15:0] hi,
		input logic [15:0] lo,
		input logic [7:0]  c
	);
		logic [15:0] w;
		w = (p == PTR_TEMP) ? t : ((p == PTR_UPPER) ? hi : lo);
		if (p == PTR_CFG)
			rdByte = (i == 2'd0) ? c : RD_FILL;
		else if (i == 2'd0)
			rdByte = w[15:8];
		else if (i == 2'd1)
			rdByte = w[7:0];
		else
			rdByte = RD_FILL;
	endfunction : rdByte

	// both lines see the same filter delay, so their order is kept
	thr_spike_filter #(.STABLE(SPIKE_CYCLES)) u_sclFilt (
		.clk   (clk),
		.rst   (rst),
		.pinIn (sclIn),
		.level (sclF)
	); // R11
	thr_spike_filter #(.STABLE(SPIKE_CYCLES)) u_sdaFilt (
		.clk   (clk),
		.rst   (rst),
		.pinIn (sdaIn),
		.level (sdaF)
	); // R11

	thr_nv_mem u_nvMem (
		.clk (clk),
		.rst (rst),
		.nv  (nv.mem)
	);

	// bus events from the filtered lines; the clock line is input only
	assign sclRise  = sclF & ~q.sclD; // R9
	assign sclFall  = ~sclF & q.sclD;
	assign busStart = sclF & q.sclD & q.sdaD & ~sdaF;
	assign busStop  = sclF & q.sclD & ~q.sdaD & sdaF;
	assign nvBusy   = (q.nvCnt != '0);
	assign mask     = resMask(q.res);
	assign cfgByte  = {q.done, q.hiFlag, q.loFlag, nvBusy, q.res, nv.cfgNv}; // R5

	// commit into storage at the end of the write time
	assign nv.we    = (q.nvCnt == NW'(1)); // R7
	assign nv.waddr = q.nvAddr;
	assign nv.wdata = q.nvData;

	always_comb
	begin
		logic        cmdStart;
		logic [15:0] newT;
		cmdStart = 1'b0;
		newT = {sensorCode, 4'h0} & mask;
		n = q;
		n.adrS0 = {addressSelect2, addressSelect1, addressSelect0};
		n.adrS1 = q.adrS0;
		n.sclD = sclF;
		n.sdaD = sdaF;
		n.sdaOut = 1'b0; // R8
		if (nvBusy)
			n.nvCnt = q.nvCnt - NW'(1);

		// serial bus slave
		if (busStart)
		begin
			n.st = ST_ADDR;
			n.bitCnt = 4'h0;
			n.ackPh = 1'b0;
			n.sdaOe = 1'b0;
		end
		else if (busStop)
		begin
			n.st = ST_IDLE;
			n.ackPh = 1'b0;
			n.sdaOe = 1'b0; // R8
		end
		else if (sclRise && q.st != ST_IDLE)
		begin
			if (q.ackPh)
				n.hostAck = ~sdaF;
			else if (q.bitCnt < 4'h8)
			begin
				n.rx = {q.rx[6:0], sdaF};
				n.bitCnt = q.bitCnt + 4'h1;
			end
		end
		else if (sclFall && q.st != ST_IDLE)
		begin
			if (q.ackPh)
			begin
				// our own ack on the address sets hostAck, so the first read byte loads here
				n.ackPh = 1'b0;
				n.bitCnt = 4'h0;
				n.sdaOe = 1'b0;
				if (q.st == ST_RDATA)
				begin
					if (q.hostAck)
					begin
						n.byteIdx = q.byteIdx + 2'd1;
						n.tx = rdByte(q.ptr, n.byteIdx, q.temp & mask, nv.upper & mask,
							nv.lower & mask, cfgByte); // R13
						n.sdaOe = ~n.tx[7]; // R8
					end
					else
						n.st = ST_IDLE;
				end
			end
			else if (q.bitCnt == 4'h8)
			begin
				n.sdaOe = 1'b0;
				n.ackPh = 1'b1;
				case (q.st)
					ST_ADDR:
					begin
						if (q.rx[7:1] == {BUS_ADDR_FIXED, q.adrS1})
						begin
							n.sdaOe = 1'b1; // R8
							n.byteIdx = 2'd3;
							n.st = q.rx[0] ? ST_RDATA : ST_CMD;
						end
						else
						begin
							n.ackPh = 1'b0;
							n.st = ST_IDLE;
						end
					end
					ST_CMD:
					begin
						n.sdaOe = 1'b1;
						n.byteIdx = 2'd0;
						n.st = ST_WDATA;
						case (q.rx)
							CMD_START:
							begin
								cmdStart = 1'b1;
								n.convRun = 1'b1;
								n.done = 1'b0;
								n.convCnt = convLen(q.res); // R15
							end
							CMD_STOP:  n.convRun = 1'b0;
							CMD_TEMP:  n.ptr = PTR_TEMP;
							CMD_UPPER: n.ptr = PTR_UPPER;
							CMD_LOWER: n.ptr = PTR_LOWER;
							CMD_CFG:   n.ptr = PTR_CFG;
							default:
							begin
								// unknown command is not acknowledged
								n.sdaOe = 1'b0;
								n.ackPh = 1'b0;
								n.st = ST_IDLE;
							end
						endcase
					end
					ST_WDATA:
					begin
						n.sdaOe = 1'b1;
						if (q.byteIdx != 2'd3)
							n.byteIdx = q.byteIdx + 2'd1;
						case (q.ptr)
							PTR_CFG:
							begin
								if (q.byteIdx == 2'd0)
								begin
									n.res = q.rx[CFG_RES_HI:CFG_RES_LO]; // R12
									// flags only clear by writing zero; done and busy are read-only
									n.hiFlag = q.hiFlag & q.rx[CFG_HIGH_FLAG]; // R16
									n.loFlag = q.loFlag & q.rx[CFG_LOW_FLAG]; // R16
									if (!nvBusy)
									begin
										n.nvCnt = NW'(NVW_CYCLES); // R7
										n.nvAddr = MEM_CFG;
										n.nvData = {14'h0000, q.rx[CFG_POL:CFG_ONESHOT]}; // R5
									end
								end
							end
							PTR_UPPER, PTR_LOWER:
							begin
								if (q.byteIdx == 2'd0)
									n.wrMsb = q.rx;
								else if (q.byteIdx == 2'd1 && !nvBusy)
								begin
									// a write during a running commit is dropped
									n.nvCnt = NW'(NVW_CYCLES); // R7
									n.nvAddr = (q.ptr == PTR_UPPER) ? MEM_UPPER : MEM_LOWER; // R3 R4
									n.nvData = {q.wrMsb, q.rx};
								end
							end
							default: n.wrMsb = q.wrMsb; // R16
						endcase
					end
					default: n.ackPh = 1'b1;
				endcase
			end
			else if (q.st == ST_RDATA)
				n.sdaOe = ~q.tx[3'(4'h7 - q.bitCnt)]; // R8
		end

		// conversion timer; flags set after host clears, so a set wins
		if (q.convRun && !cmdStart)
		begin
			if (q.convCnt > CW'(1))
				n.convCnt = q.convCnt - CW'(1);
			else
			begin
				n.temp = newT; // R1 R13
				n.done = 1'b1;
				if ($signed(newT) >= $signed(nv.upper & mask))
					n.thermActive = 1'b1; // R14
				else if ($signed(newT) < $signed(nv.lower & mask))
					n.thermActive = 1'b0; // R14
				if ($signed(newT) > $signed(nv.upper & mask))
					n.hiFlag = 1'b1;
				if ($signed(newT) < $signed(nv.lower & mask))
					n.loFlag = 1'b1;
				if (nv.cfgNv[CFG_ONESHOT])
					n.convRun = 1'b0;
				n.convCnt = convLen(q.res);
			end
		end

		// push-pull thermostat level, active state per polarity bit
		n.thermostat_output = nv.cfgNv[CFG_POL] ? n.thermActive : ~n.thermActive; // R10
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q        <= '0;
			q.adrS0  <= 3'h0;
			q.sclD   <= 1'b1;
			q.sdaD   <= 1'b1;
			q.st     <= ST_IDLE;
			q.ptr    <= PTR_TEMP;
			q.temp   <= TEMP_POR; // R2
			q.done   <= CFG_VOL_POR[5]; // R6
			q.hiFlag <= CFG_VOL_POR[4];
			q.loFlag <= CFG_VOL_POR[3];
			q.res    <= CFG_VOL_POR[1:0]; // R12
		end
		else
			q <= n;
	end

	assign sdaOut           = q.sdaOut;
	assign sdaOe            = q.sdaOe;
	assign thermostatOutput = q.thermostat_output;
endmodule : thr_thermo_core
`default_nettype wire

/* verif/thr_thermo_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_thermo_core_properties #(
	parameter int CONV_CYCLES = 400,
	parameter int NVW_CYCLES  = 50
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sclIn,
	input wire logic        sdaIn,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic        thermostatOutput,
	input wire logic        addressSelect0,
	input wire logic        addressSelect1,
	input wire logic        addressSelect2,
	input wire logic [11:0] sensorCode
);
	logic [7:0] sclRun_r;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// cycles since the raw clock pin last moved, saturating
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sclRun_r <= 8'h00;
		else
			sclRun_r <= $changed(sclIn) ? 8'h00 : sclRun_r + {7'h00, sclRun_r != 8'hFF};
	end
	// data pin is only ever pulled low
	property p_sda_out_zero; sdaOut == 1'b0; endproperty
	a_sda_out_zero: assert property (p_sda_out_zero) else $error("data output not low");
	// a short clock pulse must not move the data drive
	property p_oe_filter; !$stable(sdaOe) |-> !sclIn && sclRun_r >= 14; endproperty
	a_oe_filter: assert property (p_oe_filter) else $error("data drive moved too soon");
	property p_oe_hold; !$stable(sdaOe) |=> $stable(sdaOe) [*8]; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("data drive did not stand");
	// long clock high means idle or framing, never a device bit
	property p_idle_release; sclIn && sclRun_r >= 30 |-> !sdaOe; endproperty
	a_idle_release: assert property (p_idle_release) else $error("data driven while idle");
	property p_stop_release; sclIn && $rose(sdaIn) |=> (!sdaOe) [*8]; endproperty
	a_stop_release: assert property (p_stop_release) else $error("data driven after stop");
	property p_thermostat_output_reset; $fell(rst) |=> thermostatOutput; endproperty
	a_thermostat_output_reset: assert property (p_thermostat_output_reset) else $error("thermostat not driven inactive");
	property p_rst_idle; $fell(rst) |-> !sdaOe ##1 !sdaOe; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("data driven after reset");
	// thermostat moves only at conversion ends, polarity commits, reset entry and reset release, which are far apart
	property p_thermostat_output_hold; !$stable(thermostatOutput) |=> $stable(thermostatOutput) [*8]; endproperty
	a_thermostat_output_hold: assert property (p_thermostat_output_hold) else $error("thermostat toggled too fast");
endmodule : thr_thermo_core_properties
bind thr_thermo_core thr_thermo_core_properties #(.CONV_CYCLES(CONV_CYCLES), .NVW_CYCLES(NVW_CYCLES)) i_props (
	.clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.thermostatOutput(thermostatOutput), .addressSelect0(addressSelect0),
	.addressSelect1(addressSelect1), .addressSelect2(addressSelect2), .sensorCode(sensorCode)
);
`default_nettype wire

/* verif/thr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_host_model (
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaLow
);
	// bus idles released with the clock high
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// start or repeated start; long low lets the device drop its ack first
	task automatic start();
		sdaLow <= 1'b0;
		tick(20);
		scl <= 1'b1;
		tick(20);
		sdaLow <= 1'b1;
		tick(20);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		tick(10);
		sdaLow <= 1'b1;
		tick(20);
		scl <= 1'b1;
		tick(20);
		sdaLow <= 1'b0;
		tick(40);
	endtask : stop
	// one bit, b=1 releases the line; optional 48 ns clock spike in the low phase
	task automatic bitX(input logic b, input logic spike, output logic r);
		tick(10);
		sdaLow <= !b;
		if (spike)
		begin
			tick(4);
			scl <= 1'b1;
			tick(12);
			scl <= 1'b0;
		end
		tick(spike ? 30 : 10);
		scl <= 1'b1;
		tick(10);
		r = sdaWire;
		tick(10);
		scl <= 1'b0;
	endtask : bitX
	// eight bits msb first, then the acknowledge slot
	task automatic byteX(input logic [7:0] d, input logic spike, input logic ackBit,
		output logic [7:0] q, output logic ackSeen);
		for (int i = 7; i >= 0; i--)
			bitX(d[i], spike && i == 3, q[i]);
		bitX(ackBit, 1'b0, ackSeen);
	endtask : byteX
endmodule : thr_host_model
`default_nettype wire

/* verif/thr_thermo_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_thermo_core_tb;
	import thr_pkg::*;
	localparam int CONV = 400;
	localparam int NVW = 4000;
	localparam logic [7:0] ADDR_W = {BUS_ADDR_FIXED, 3'h5, 1'b0};
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] exp;
	} thr_row_s;
	thr_row_s    rows [4] = '{'{CMD_TEMP, 16'hC400}, '{CMD_UPPER, 16'h0F00},
		'{CMD_LOWER, 16'h0A00}, '{CMD_CFG, 16'h8CFF}};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sdaOe;
	logic        sdaWire;
	logic        scl;
	logic        hostLow;
	logic        thermostat_output;
	logic        nack;
	logic [7:0]  q;
	logic [11:0] sensorCode = 12'h000;
	logic [15:0] rd;
	int          fails = 0;
	int          checksDone = 0;
	int          cycles = 0;
	// open-drain data wire with pull-up
	assign sdaWire = !(sdaOe || hostLow);
	always #2 clk = !clk;
	thr_thermo_core #(.CONV_CYCLES(CONV), .NVW_CYCLES(NVW)) i_dut (
		.clk              (clk),
		.rst              (rst),
		.sclIn            (scl),
		.sdaIn            (sdaWire),
		.sdaOut           (),
		.sdaOe            (sdaOe),
		.thermostatOutput (thermostat_output),
		.addressSelect0   (1'b1),
		.addressSelect1   (1'b0),
		.addressSelect2   (1'b1),
		.sensorCode       (sensorCode)
	);
	thr_host_model i_host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim(input int extra);
		fails += extra;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// one written byte, acknowledge expected
	task automatic wr(input logic [7:0] d, input logic spike);
		i_host.byteX(d, spike, 1'b1, q, nack);
		check({15'h0, nack}, 16'h0);
	endtask : wr
	task automatic head(input logic [7:0] cmd, input logic spike);
		i_host.start();
		wr(ADDR_W, spike);
		wr(cmd, 1'b0);
	endtask : head
	task automatic regWrite(input logic [7:0] cmd, input int n, input logic [15:0] d);
		head(cmd, 1'b0);
		if (n > 0)
			wr(d[15:8], 1'b0);
		if (n > 1)
			wr(d[7:0], 1'b0);
		i_host.stop();
	endtask : regWrite
	// pointer set, repeated start, two bytes msb first, last one refused
	task automatic regRead(input logic [7:0] cmd, input logic [15:0] exp);
		head(cmd, 1'b0);
		i_host.start();
		wr(ADDR_W | 8'h01, 1'b0);
		i_host.byteX(8'hFF, 1'b0, 1'b0, rd[15:8], nack);
		i_host.byteX(8'hFF, 1'b0, 1'b1, rd[7:0], nack);
		i_host.stop();
		check(rd, exp);
	endtask : regRead
	// ceiling about 1.6 times the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
			end_sim(1);
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (20) @(posedge clk);
		foreach (rows[i])
			regRead(rows[i].cmd, rows[i].exp);
		$display("test power-up values done");
		// wrong address must be left unanswered
		i_host.start();
		i_host.byteX(ADDR_W ^ 8'h02, 1'b0, 1'b1, q, nack);
		check({15'h0, nack}, 16'h1);
		i_host.stop();
		// temperature write with a clock spike in the address byte
		head(CMD_TEMP, 1'b1);
		wr(8'h12, 1'b0);
		wr(8'h34, 1'b0);
		i_host.stop();
		regRead(CMD_TEMP, 16'hC400);
		$display("test refusals done");
		regWrite(CMD_UPPER, 2, 16'h191F);
		regRead(CMD_CFG, 16'h9CFF);
		repeat (NVW) @(posedge clk);
		regRead(CMD_UPPER, 16'h1910);
		$display("test trip write done");
		sensorCode <= 12'h191;
		regWrite(CMD_START, 0, 16'h0000);
		repeat (CONV + 50) @(posedge clk);
		regRead(CMD_TEMP, 16'h1910);
		check({15'h0, thermostat_output}, 16'h0);
		sensorCode <= 12'h0A0;
		repeat (CONV + 50) @(posedge clk);
		check({15'h0, thermostat_output}, 16'h0);
		sensorCode <= 12'h09F;
		repeat (CONV + 50) @(posedge clk);
		check({15'h0, thermostat_output}, 16'h1);
		regRead(CMD_CFG, 16'hACFF);
		regWrite(CMD_STOP, 0, 16'h0000);
		regWrite(CMD_CFG, 1, 16'h0000);
		regRead(CMD_CFG, 16'h90FF);
		regRead(CMD_TEMP, 16'h0980);
		regRead(CMD_UPPER, 16'h1900);
		$display("test conversion done");
		// polarity and single-conversion bits set; earlier commit must finish first
		repeat (NVW) @(posedge clk);
		regWrite(CMD_CFG, 1, 16'h0300);
		repeat (NVW) @(posedge clk);
		regRead(CMD_CFG, 16'h83FF);
		check({15'h0, thermostat_output}, 16'h0);
		sensorCode <= 12'h200;
		regWrite(CMD_START, 0, 16'h0000);
		repeat (CONV + 50) @(posedge clk);
		check({15'h0, thermostat_output}, 16'h1);
		// single conversion stops, so a new sensor value is never taken
		sensorCode <= 12'h000;
		repeat (CONV + 50) @(posedge clk);
		regRead(CMD_TEMP, 16'h2000);
		$display("test polarity and single conversion done");
		// second reset in mid-run
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		check({14'h0, sdaOe, thermostat_output}, 16'h0);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0, thermostat_output}, 16'h1);
		repeat (20) @(posedge clk);
		regRead(CMD_TEMP, 16'hC400);
		regRead(CMD_CFG, 16'h8CFF);
		$display("test second reset done");
		end_sim(0);
	end
endmodule : thr_thermo_core_tb
`default_nettype wire
